// file: hw/debug_serial_pkg.sv
// constants, carriers and helpers for the debug serial port
package debug_serial_pkg;

  localparam int WORD_BITS = 17;
  localparam int DATA_BITS = 16;
  localparam int ADDR_W = 5;

  // received-bit counter values
  localparam logic [4:0] BIT_COUNT_FULL = 5'h11;
  localparam logic [4:0] BIT_COUNT_ZERO = 5'h00;
  localparam logic [4:0] BIT_COUNT_STEP = 5'h01;

  // reply data patterns
  localparam logic [15:0] DATA_NOT_READY = 16'h0000;
  localparam logic [15:0] DATA_BUS_ERROR = 16'h0001;
  localparam logic [15:0] DATA_ALL_ONES = 16'hFFFF;

  // reply kinds written by software into the response register
  localparam logic [1:0] KIND_VALID = 2'h0;
  localparam logic [1:0] KIND_COMPLETE = 2'h1;
  localparam logic [1:0] KIND_BUS_ERROR = 2'h2;
  localparam logic [1:0] KIND_ILLEGAL = 2'h3;
  localparam int RESP_KIND_LSB = 16;

  // command word fields
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 10;
  localparam int DIR_BIT = 7;
  localparam int SIZE_MSB = 5;
  localparam int SIZE_LSB = 4;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  localparam logic [1:0] SIZE_RESERVED = 2'h3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_RXDATA = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_RESP = 5'h0C;
  localparam logic [ADDR_W-1:0] ADDR_FIELDS = 5'h10;

  localparam int CTRL_ENABLE_BIT = 0;
  localparam int ST_RX_READY = 0;
  localparam int ST_ACTIVE = 1;
  localparam int ST_PENDING = 2;
  localparam int ST_SIZE_RSVD = 3;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef struct packed {
    logic sc;
    logic [15:0] data;
  } reply_s;

  typedef struct packed {
    logic [5:0] op;
    logic dir;
    logic [1:0] size;
    logic [15:0] data;
  } rx_word_s;

  localparam reply_s REPLY_NOT_READY = '{sc: 1'b1, data: DATA_NOT_READY};

  function automatic reply_s make_reply(input logic [1:0] kind,
                                        input logic [15:0] data);
    reply_s r;
    r = '{sc: 1'b0, data: data};
    case (kind)
      KIND_COMPLETE: r = '{sc: 1'b0, data: DATA_ALL_ONES};
      KIND_BUS_ERROR: r = '{sc: 1'b1, data: DATA_BUS_ERROR};
      KIND_ILLEGAL: r = '{sc: 1'b1, data: DATA_ALL_ONES};
      default: r = '{sc: 1'b0, data: data};
    endcase
    return r;
  endfunction

  function automatic rx_word_s decode_word(input logic [15:0] data);
    rx_word_s w;
    w.op = data[OP_MSB:OP_LSB];
    w.dir = data[DIR_BIT];
    w.size = data[SIZE_MSB:SIZE_LSB];
    w.data = data;
    return w;
  endfunction

endpackage

// file: hw/pin_sync.sv
// two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage is read only by the second stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // pin_sync

// file: hw/debug_serial_port.sv
// debug serial port: 17-bit full-duplex link with AXI4-Lite registers
`timescale 1ns/1ps
module debug_serial_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [debug_serial_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [debug_serial_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic breakpoint_request_n,
  input wire logic fetch_status_pin,
  input wire logic pipe_status_normal,
  output logic pipe_status_pin,
  output logic core_breakpoint_n,
  output logic background_debug_state,
  output logic core_release
);

  logic [1:0] pins_raw;
  logic [1:0] pins_sync;
  logic sclk_s;
  logic sdi_s;
  logic sclk_prev_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic [16:0] rx_shift_reg;
  logic [4:0] bit_count_reg;
  logic step_reg;
  debug_serial_pkg::reply_s tx_reg;
  debug_serial_pkg::reply_s resp_reg;
  debug_serial_pkg::rx_word_s rx_latch_reg;
  logic resp_pending_reg;
  logic rx_ready_reg;
  logic ctrl_enable_reg;
  logic core_release_reg;
  logic active;
  logic word_done;
  logic resp_load;
  logic w_fire;
  logic r_fire;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_word;
  logic rd_ok;
  logic [31:0] wr_word;

  function automatic logic [31:0] apply_strobes(input logic [31:0] old,
                                                input logic [31:0] din,
                                                input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = din[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // pins are asynchronous to aclk; a slow serial clock is assumed
  assign pins_raw = {breakpoint_request_n, fetch_status_pin};

  pin_sync #(
    .WIDTH(2),
    .RESET_VALUE(2'h3)
  ) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  assign sclk_s = pins_sync[1];
  assign sdi_s = pins_sync[0];

  // idle-high clock: reset the history high so no false edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sclk_prev_reg <= 1'b1;
    end
    else
    begin
      sclk_prev_reg <= sclk_s;
    end
  end

  // falling edges are observed only so they can be ignored
  assign sclk_rise = ctrl_enable_reg && sclk_s && !sclk_prev_reg;
  assign sclk_fall = ctrl_enable_reg && !sclk_s && sclk_prev_reg;

  assign active = bit_count_reg != debug_serial_pkg::BIT_COUNT_FULL;
  assign word_done = step_reg &&
                     (bit_count_reg == debug_serial_pkg::BIT_COUNT_ZERO);
  // result data waits until the link is idle
  assign resp_load = resp_pending_reg && !active && !step_reg &&
                     !sclk_rise;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_shift_reg <= '0;
    end
    else if (sclk_rise)
    begin
      rx_shift_reg <= {rx_shift_reg[15:0], sdi_s};
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ctrl_enable_reg)
    begin
      bit_count_reg <= debug_serial_pkg::BIT_COUNT_FULL;
    end
    else if (word_done)
    begin
      bit_count_reg <= debug_serial_pkg::BIT_COUNT_FULL;
    end
    else if (sclk_rise)
    begin
      bit_count_reg <= bit_count_reg -
                       debug_serial_pkg::BIT_COUNT_STEP;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      step_reg <= 1'b0;
    end
    else
    begin
      step_reg <= sclk_rise;
    end
  end

  // one cycle after the edge: shift out next bit, or close the word
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_reg <= debug_serial_pkg::REPLY_NOT_READY;
    end
    else if (word_done)
    begin
      tx_reg <= debug_serial_pkg::REPLY_NOT_READY;
    end
    else if (step_reg)
    begin
      tx_reg <= debug_serial_pkg::reply_s'({tx_reg[15:0], 1'b0});
    end
    else if (resp_load)
    begin
      tx_reg <= resp_reg;
    end
  end

  // the received status bit is dropped here
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_latch_reg <= '0;
    end
    else if (word_done)
    begin
      rx_latch_reg <= debug_serial_pkg::decode_word(
                        rx_shift_reg[15:0]);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_release_reg <= 1'b0;
    end
    else
    begin
      core_release_reg <= word_done;
    end
  end

  // a new word beats a clearing read in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_ready_reg <= 1'b0;
    end
    else if (word_done)
    begin
      rx_ready_reg <= 1'b1;
    end
    else if (r_fire && s_axi_araddr == debug_serial_pkg::ADDR_RXDATA)
    begin
      rx_ready_reg <= 1'b0;
    end
  end

  assign w_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign r_fire = s_axi_arvalid && !rvalid_reg;
  assign wr_word = apply_strobes('0, s_axi_wdata, s_axi_wstrb);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_enable_reg <= 1'b0;
    end
    else if (w_fire && s_axi_awaddr == debug_serial_pkg::ADDR_CTRL)
    begin
      ctrl_enable_reg <= wr_word[debug_serial_pkg::CTRL_ENABLE_BIT];
    end
  end

  // a later write replaces a response still waiting for the link
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      resp_reg <= debug_serial_pkg::REPLY_NOT_READY;
      resp_pending_reg <= 1'b0;
    end
    else if (w_fire && s_axi_awaddr == debug_serial_pkg::ADDR_RESP)
    begin
      resp_reg <= debug_serial_pkg::make_reply(
                    wr_word[debug_serial_pkg::RESP_KIND_LSB +: 2],
                    wr_word[15:0]);
      resp_pending_reg <= 1'b1;
    end
    else if (resp_load)
    begin
      resp_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= debug_serial_pkg::AXI_OKAY;
    end
    else if (w_fire)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (s_axi_awaddr == debug_serial_pkg::ADDR_CTRL ||
                    s_axi_awaddr == debug_serial_pkg::ADDR_RESP) ?
                   debug_serial_pkg::AXI_OKAY :
                   debug_serial_pkg::AXI_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_reg <= 1'b0;
    end
  end

  always_comb
  begin
    rd_word = '0;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      debug_serial_pkg::ADDR_CTRL:
        rd_word[debug_serial_pkg::CTRL_ENABLE_BIT] = ctrl_enable_reg;
      debug_serial_pkg::ADDR_STATUS:
      begin
        rd_word[debug_serial_pkg::ST_RX_READY] = rx_ready_reg;
        rd_word[debug_serial_pkg::ST_ACTIVE] = active;
        rd_word[debug_serial_pkg::ST_PENDING] = resp_pending_reg;
        rd_word[debug_serial_pkg::ST_SIZE_RSVD] =
          rx_latch_reg.size == debug_serial_pkg::SIZE_RESERVED;
      end
      debug_serial_pkg::ADDR_RXDATA:
        rd_word[15:0] = rx_latch_reg.data;
      debug_serial_pkg::ADDR_FIELDS:
        rd_word = 32'({rx_latch_reg.size, rx_latch_reg.dir,
                       rx_latch_reg.op});
      default:
        rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= debug_serial_pkg::AXI_OKAY;
    end
    else if (r_fire)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_ok ? debug_serial_pkg::AXI_OKAY :
                   debug_serial_pkg::AXI_SLVERR;
    end
    else if (s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_awready = s_axi_wvalid && !bvalid_reg;
  assign s_axi_wready = s_axi_awvalid && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // status bit of the word leads the pin, so a load shows at once
  assign pipe_status_pin = ctrl_enable_reg ? tx_reg.sc :
                           pipe_status_normal;
  assign core_breakpoint_n = ctrl_enable_reg ? 1'b1 : sclk_s;
  assign background_debug_state = ctrl_enable_reg;
  assign core_release = core_release_reg;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence edge_seen;
    sclk_rise && bit_count_reg != debug_serial_pkg::BIT_COUNT_ZERO;
  endsequence

  sequence word_closed;
    step_reg && bit_count_reg == debug_serial_pkg::BIT_COUNT_ZERO;
  endsequence

  sync_delay_a: assert property ($past(aresetn, 3) |->
    pins_sync == $past(pins_raw, 2))
    else $error("pins not delayed by two flops");

  count_down_a: assert property (edge_seen |=>
    bit_count_reg == $past(bit_count_reg) -
    debug_serial_pkg::BIT_COUNT_STEP ##0 step_reg)
    else $error("counter not decremented on edge");

  tx_shift_a: assert property (step_reg &&
    bit_count_reg != debug_serial_pkg::BIT_COUNT_ZERO |=>
    tx_reg[16:1] == $past(tx_reg[15:0]))
    else $error("transmit word not shifted");

  word_latch_a: assert property (sclk_rise &&
    bit_count_reg == debug_serial_pkg::BIT_COUNT_STEP ##1 word_closed
    |=> rx_latch_reg.data == $past(rx_shift_reg[15:0]) &&
    tx_reg == debug_serial_pkg::REPLY_NOT_READY && core_release)
    else $error("word not latched with not-ready reload");

  count_reload_a: assert property (word_closed |=>
    bit_count_reg == debug_serial_pkg::BIT_COUNT_FULL)
    else $error("counter not reloaded to seventeen");

  hold_in_xfer_a: assert property (active && !step_reg |=>
    $stable(tx_reg))
    else $error("transmit word changed during transfer");

  no_fall_a: assert property (sclk_fall |=>
    $stable(bit_count_reg) && $stable(rx_shift_reg))
    else $error("falling edge changed serial state");

  resp_drive_a: assert property (resp_load && ctrl_enable_reg |=>
    tx_reg == $past(resp_reg) && pipe_status_pin == $past(resp_reg.sc))
    else $error("response not driven after load");

  // error kinds must come out with the status bit set, whatever the data
  error_high_a: assert property (w_fire &&
    s_axi_awaddr == debug_serial_pkg::ADDR_RESP &&
    wr_word[debug_serial_pkg::RESP_KIND_LSB +: 2] >=
    debug_serial_pkg::KIND_BUS_ERROR |=> resp_reg.sc && resp_pending_reg)
    else $error("error reply lost its status bit");

endmodule // debug_serial_port

// file: verification/debug_host_model.sv
// host-side serial master model for the debug serial port
`timescale 1ns/1ps
module debug_host_model #(
  parameter int HALF_NS = 32
) (
  output logic serial_clock,
  output logic serial_data,
  input wire logic serial_in
);
  // 64 ns period keeps the link well under half the system clock
  initial
  begin
    serial_clock = 1'b1; // idles high between words
    serial_data = 1'b0;
  end

  // breakpoint asked for by pulling the clock line low
  // zero length latches it until the first shift releases it
  task automatic request_break(input int low_ns);
    #2;
    serial_clock = 1'b0;
    if (low_ns > 0)
    begin
      #(low_ns);
      serial_clock = 1'b1;
    end
  endtask

  // one full-duplex word, msb first, clock made here
  task automatic xfer(input logic [16:0] tx, output logic [16:0] rx);
    // host is unrelated to aclk: keep its edges off the sampling edge
    #2;
    for (int i = 16; i >= 0; i--)
    begin
      serial_clock = 1'b0;
      #4;
      serial_data = tx[i]; // moves only after the falling edge
      #(HALF_NS - 4);
      rx[i] = serial_in;
      serial_clock = 1'b1;
      #(HALF_NS);
    end
    // clock stays high after the last shift
    serial_data = ~tx[0]; // released line must not show a stale bit
    #(HALF_NS);
  endtask
endmodule // debug_host_model

// file: verification/tb.sv
// self-checking bench for the debug serial port
`timescale 1ns/1ps
module tb;
  logic aclk, aresetn;
  logic [debug_serial_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic breakpoint_request_n, fetch_status_pin, pipe_status_normal;
  logic pipe_status_pin, core_breakpoint_n, background_debug_state;
  logic core_release;
  int error_cnt = 0;
  int samples_checked = 0;
  int release_cnt = 0;

  debug_serial_port debug_serial_port_i (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .breakpoint_request_n, .fetch_status_pin, .pipe_status_normal,
    .pipe_status_pin, .core_breakpoint_n, .background_debug_state,
    .core_release);
  debug_host_model debug_host_model_i (.serial_clock(breakpoint_request_n),
    .serial_data(fetch_status_pin), .serial_in(pipe_status_pin));

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // a stuck release would be counted many times
  always @(posedge aclk)
    if (core_release === 1'b1) release_cnt++;

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen,
        exp);
    end
  endtask

  task automatic guard(input int n);
    if (n > 200)
    begin
      error_cnt++;
      finish_test();
    end
  endtask

  // entered just after a rising edge; leaves one spare edge at the end
  task automatic axi_wr(input logic [debug_serial_pkg::ADDR_W-1:0] a,
                        input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw, w;
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w)
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) aw = 1'b0;
      if (s_axi_wready === 1'b1) w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
      guard(n);
    end
    do
    begin
      @(posedge aclk);
      n++;
      guard(n);
    end while (s_axi_bvalid !== 1'b1);
    check(32'(s_axi_bresp), 32'(er));
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd_chk(input logic [debug_serial_pkg::ADDR_W-1:0] a,
                        input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      guard(n);
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do
    begin
      @(posedge aclk);
      n++;
      guard(n);
    end while (s_axi_rvalid !== 1'b1);
    check(s_axi_rdata, exp);
    check(32'(s_axi_rresp), 32'(er));
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  initial
  begin
    logic [16:0] rx;
    logic [16:0] exp_rep;
    logic [15:0] w;
    int n;
    aresetn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    pipe_status_normal = 1'b1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check(32'(pipe_status_pin), 32'h1);
    pipe_status_normal <= 1'b0;
    @(posedge aclk);
    check(32'(pipe_status_pin), 32'h0);
    rd_chk(debug_serial_pkg::ADDR_STATUS, 32'h0, 2'h0);
    rd_chk(debug_serial_pkg::ADDR_CTRL, 32'h0, 2'h0);
    rd_chk(5'h14, 32'h0, debug_serial_pkg::AXI_SLVERR);
    axi_wr(debug_serial_pkg::ADDR_STATUS, 32'h1, debug_serial_pkg::AXI_SLVERR);
    $display("test reset and bus done");

    n = 0;
    debug_host_model_i.request_break(0);
    while (core_breakpoint_n !== 1'b0)
    begin
      @(posedge aclk);
      n++;
      guard(n);
    end
    check(32'(n < 5), 32'h1);
    axi_wr(debug_serial_pkg::ADDR_CTRL, 32'h1, 2'h0);
    check(32'(background_debug_state), 32'h1);
    check(32'(pipe_status_pin), 32'h1);
    check(32'(core_breakpoint_n), 32'h1);
    $display("test breakpoint and entry done");

    w = 16'hA4B0;
    debug_host_model_i.xfer({1'b1, w}, rx);
    repeat (4) @(posedge aclk);
    check(32'(rx), 32'h10000);
    check(32'(release_cnt), 32'h1);
    check(32'(pipe_status_pin), 32'h1);
    rd_chk(debug_serial_pkg::ADDR_FIELDS,
      {23'h0, w[5:4], w[7], w[15:10]}, 2'h0);
    rd_chk(debug_serial_pkg::ADDR_STATUS, 32'h9, 2'h0);
    rd_chk(debug_serial_pkg::ADDR_RXDATA, {16'h0, w}, 2'h0);
    rd_chk(debug_serial_pkg::ADDR_STATUS, 32'h8, 2'h0);
    $display("test first word done");

    for (int k = 0; k < 4; k++)
    begin
      w = {6'(k * 9 + 3), 2'h0, k[0], 1'b0, k[1:0], 4'h6};
      exp_rep = (k == 0) ? 17'h05A3C : (k == 1) ? 17'h0FFFF :
        (k == 2) ? 17'h10001 : 17'h1FFFF;
      axi_wr(debug_serial_pkg::ADDR_RESP, {14'h0, k[1:0], 16'h5A3C},
        2'h0);
      n = 0;
      while (pipe_status_pin !== exp_rep[16])
      begin
        @(posedge aclk);
        n++;
        guard(n);
      end
      check(32'(pipe_status_pin), 32'(exp_rep[16]));
      debug_host_model_i.xfer({1'b0, w}, rx);
      repeat (4) @(posedge aclk);
      check(32'(rx), 32'(exp_rep));
      check(32'(release_cnt), 32'(k + 2));
      check(32'(pipe_status_pin), 32'h1);
      rd_chk(debug_serial_pkg::ADDR_FIELDS,
        {23'h0, w[5:4], w[7], w[15:10]}, 2'h0);
      rd_chk(debug_serial_pkg::ADDR_STATUS,
        {28'h0, k == 3, 3'b001}, 2'h0);
    end
    $display("test reply kinds done");

    fork
      debug_host_model_i.xfer(17'h0C801, rx);
      begin
        repeat (40) @(posedge aclk);
        axi_wr(debug_serial_pkg::ADDR_RESP,
          {14'h0, debug_serial_pkg::KIND_COMPLETE, 16'h0}, 2'h0);
        rd_chk(debug_serial_pkg::ADDR_STATUS, 32'hF, 2'h0);
      end
    join
    repeat (4) @(posedge aclk);
    check(32'(rx), 32'h10000);
    check(32'(pipe_status_pin), 32'h0);
    debug_host_model_i.xfer(17'h02400, rx);
    repeat (4) @(posedge aclk);
    check(32'(rx), 32'h0FFFF);
    $display("test deferred response done");
    finish_test();
  end
endmodule // tb
